/* File: logic/flash_mode_pkg.sv */
// Constants and carriers for the flash mode key unlock block
// Contract
// - Read-only idle flag at bit 24: 0 while program or erase runs, else 1.
// - Key 0x5A then 0xA5 enters program/erase mode, setting entry and status bits.
// - Key 0xA5 then 0x5A enters trim mode, setting trim entry and status bits.
// - Key 0x81 then 0x28 sets read-only bus-configuration enable bit 22.
// - Key 0x66 then 0x99 sets read-only protection-access enable bit 21.
// - Key 0x39 then 0x7D sets read-only factory test enable bit 23.
// - Protection register access is blocked unless protection-access enable is 1.
// - Test control field writes are ignored unless factory test enable is 1.
// - Bus-configuration settings change only while its enable bit reads 1.
// - Program/erase status bit 8 is set together with entry bit 9.
// - Trim status bit 16 is set together with trim entry bit 17.
// - Mode register is one 32-bit word; only key field writable.
// - Control word bits 17:0 writable only while program/erase entry is active.
// - Control bits 30:28 need trim mode; bits 31 and 27:24 need bus-config mode.
`default_nettype none
package flash_mode_pkg;
    localparam logic [31:0] MODE_REG_ADDR     = 32'h40000104;
    localparam logic [31:0] CTRL_REG_ADDR     = 32'h40000108;
    localparam logic [31:0] WPROT_REG_ADDR    = 32'h40000178;
    localparam logic [31:0] RPROT_REG_ADDR    = 32'h4000017C;
    localparam logic [31:0] MODE_RESET        = 32'h01000000;
    localparam logic [31:0] CTRL_RESET        = 32'h05000000;
    localparam logic [31:0] WPROT_RESET       = 32'h00FFFF00;
    localparam logic [31:0] RPROT_RESET       = 32'h000000FF;
    localparam int          IDLE_BIT          = 24;
    localparam int          TEST_EN_BIT       = 23;
    localparam int          BUSCFG_EN_BIT     = 22;
    localparam int          PROT_EN_BIT       = 21;
    localparam int          TRIM_ENTRY_BIT    = 17;
    localparam int          TRIM_STATUS_BIT   = 16;
    localparam int          PE_ENTRY_BIT      = 9;
    localparam int          PE_STATUS_BIT     = 8;
    localparam int          PGM_BIT           = 2;
    localparam int          ERS_BIT           = 1;
    localparam logic [31:0] CTRL_PE_MASK      = 32'h0003FFFF;
    localparam logic [31:0] CTRL_TRIM_MASK    = 32'h70000000;
    localparam logic [31:0] CTRL_BUSCFG_MASK  = 32'h8F000000;
    localparam logic [31:0] CTRL_TEST_MASK    = 32'h00030000;
    localparam int          NUM_MODES         = 5;
    localparam logic [7:0]  KEY_PE_1          = 8'h5A;
    localparam logic [7:0]  KEY_PE_2          = 8'hA5;
    localparam logic [7:0]  KEY_TRIM_1        = 8'hA5;
    localparam logic [7:0]  KEY_TRIM_2        = 8'h5A;
    localparam logic [7:0]  KEY_BUSCFG_1      = 8'h81;
    localparam logic [7:0]  KEY_BUSCFG_2      = 8'h28;
    localparam logic [7:0]  KEY_PROT_1        = 8'h66;
    localparam logic [7:0]  KEY_PROT_2        = 8'h99;
    localparam logic [7:0]  KEY_TEST_1        = 8'h39;
    localparam logic [7:0]  KEY_TEST_2        = 8'h7D;
    // Mode index order: program/erase, trim, bus-config, protection, test
    localparam logic [NUM_MODES*8-1:0] FIRST_KEYS  = {KEY_TEST_1, KEY_PROT_1,
        KEY_BUSCFG_1, KEY_TRIM_1, KEY_PE_1};
    localparam logic [NUM_MODES*8-1:0] SECOND_KEYS = {KEY_TEST_2, KEY_PROT_2,
        KEY_BUSCFG_2, KEY_TRIM_2, KEY_PE_2};

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic prog_erase;
        logic trim;
        logic bus_config;
        logic protection;
        logic factory_test;
    } mode_flags_t;
endpackage
`default_nettype wire

/* File: logic/key_sequence_detect.sv */
// Two-byte key pair detector for the mode unlock sequences
`timescale 1ns/100ps
`default_nettype none
module key_sequence_detect (
    input  wire logic                                   ref_clk,   // Clock
    input  wire logic                                   srst,      // Sync reset
    input  wire logic                                   key_wr,    // Key byte written
    input  wire logic [7:0]                             key_byte,  // Written key
    output logic      [flash_mode_pkg::NUM_MODES-1:0]   grant      // Pair complete
);
    typedef struct packed {
        logic [flash_mode_pkg::NUM_MODES-1:0] armed;
    } det_state_t;

    det_state_t state_reg;
    det_state_t state_next;
    logic [flash_mode_pkg::NUM_MODES-1:0] first_hit;
    logic [flash_mode_pkg::NUM_MODES-1:0] second_hit;

    genvar g;
    generate
        for (g = 0; g < flash_mode_pkg::NUM_MODES; g++) begin : g_mode
            assign first_hit[g]  = key_byte == flash_mode_pkg::FIRST_KEYS[g*8 +: 8];
            assign second_hit[g] = key_byte == flash_mode_pkg::SECOND_KEYS[g*8 +: 8];
            assign grant[g]      = key_wr && state_reg.armed[g] && second_hit[g];
        end
    endgenerate

    always_comb begin
        state_next = state_reg;
        // Every key write rearms from scratch, so pairs must be adjacent
        if (key_wr) begin
            state_next.armed = first_hit;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule // key_sequence_detect
`default_nettype wire

/* File: logic/flash_mode_key_unlock.sv */
// Flash mode register, key unlock and gated control/protection registers
`timescale 1ns/100ps
`default_nettype none
module flash_mode_key_unlock (
    input  wire logic        ref_clk,          // 100 MHz clock
    input  wire logic        srst,             // Sync reset, active high
    input  wire logic [31:0] reg_addr,         // Register byte address
    input  wire logic [31:0] reg_wdata,        // Write data
    input  wire logic        reg_wr,           // Write strobe
    input  wire logic        reg_rd,           // Read strobe
    input  wire logic        op_busy,          // Program/erase engine busy
    output logic      [31:0] reg_rdata,        // Read data, cycle after strobe
    output logic      [31:0] flash_control_word, // Control register value
    output logic      [31:0] write_prot_word,  // Write protection register
    output logic      [31:0] read_prot_word,   // Read protection register
    output logic      [4:0]  mode_enables      // PE, trim, buscfg, prot, test
);
    typedef struct packed {
        flash_mode_pkg::mode_flags_t modes;
        logic                        idle;
        logic [7:0]                  key;
        logic [31:0]                 ctrl;
        logic [31:0]                 wprot;
        logic [31:0]                 rprot;
        logic [31:0]                 rdata;
        logic [4:0]                  en_out;
    } top_state_t;

    top_state_t                  state_reg;
    top_state_t                  state_next;
    flash_mode_pkg::reg_req_t    req;
    logic [4:0]                  grant;
    logic                        key_wr;
    logic [31:0]                 mode_word;
    logic [31:0]                 ctrl_mask;

    assign req    = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign key_wr = req.wr && (req.addr == flash_mode_pkg::MODE_REG_ADDR);

    key_sequence_detect u_keys (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .key_wr   (key_wr),
        .key_byte (req.wdata[7:0]),
        .grant    (grant)
    );

    // Assembled mode word: only the key byte is software-written
    always_comb begin
        mode_word = '0;
        mode_word[7:0]                            = state_reg.key;
        mode_word[flash_mode_pkg::IDLE_BIT]       = state_reg.idle;
        mode_word[flash_mode_pkg::TEST_EN_BIT]    = state_reg.modes.factory_test;
        mode_word[flash_mode_pkg::BUSCFG_EN_BIT]  = state_reg.modes.bus_config;
        mode_word[flash_mode_pkg::PROT_EN_BIT]    = state_reg.modes.protection;
        mode_word[flash_mode_pkg::TRIM_ENTRY_BIT] = state_reg.modes.trim;
        mode_word[flash_mode_pkg::TRIM_STATUS_BIT] = state_reg.modes.trim;
        mode_word[flash_mode_pkg::PE_ENTRY_BIT]   = state_reg.modes.prog_erase;
        mode_word[flash_mode_pkg::PE_STATUS_BIT]  = state_reg.modes.prog_erase;
    end

    // Per-field write mask of the control word from the active modes
    always_comb begin
        ctrl_mask = '0;
        if (state_reg.modes.prog_erase) begin
            ctrl_mask = ctrl_mask | flash_mode_pkg::CTRL_PE_MASK;
        end
        if (!state_reg.modes.factory_test) begin
            ctrl_mask = ctrl_mask & ~flash_mode_pkg::CTRL_TEST_MASK;
        end
        if (state_reg.modes.trim) begin
            ctrl_mask = ctrl_mask | flash_mode_pkg::CTRL_TRIM_MASK;
        end
        if (state_reg.modes.bus_config) begin
            ctrl_mask = ctrl_mask | flash_mode_pkg::CTRL_BUSCFG_MASK;
        end
    end

    always_comb begin
        state_next       = state_reg;
        state_next.rdata = '0;
        // Idle low while program or erase is underway
        state_next.idle  = !(op_busy || state_reg.ctrl[flash_mode_pkg::PGM_BIT]
                             || state_reg.ctrl[flash_mode_pkg::ERS_BIT]);
        if (key_wr) begin
            state_next.key = req.wdata[7:0];
        end
        if (grant[0]) begin
            state_next.modes.prog_erase = 1'b1;
        end
        if (grant[1]) begin
            state_next.modes.trim = 1'b1;
        end
        if (grant[2]) begin
            state_next.modes.bus_config = 1'b1;
        end
        if (grant[3]) begin
            state_next.modes.protection = 1'b1;
        end
        if (grant[4]) begin
            state_next.modes.factory_test = 1'b1;
        end
        if (req.wr) begin
            case (req.addr)
                flash_mode_pkg::CTRL_REG_ADDR: begin
                    state_next.ctrl = (state_reg.ctrl & ~ctrl_mask)
                                    | (req.wdata & ctrl_mask);
                end
                flash_mode_pkg::WPROT_REG_ADDR: begin
                    if (state_reg.modes.protection) begin
                        state_next.wprot = req.wdata;
                    end
                end
                flash_mode_pkg::RPROT_REG_ADDR: begin
                    if (state_reg.modes.protection) begin
                        state_next.rprot = req.wdata;
                    end
                end
                default: begin
                end
            endcase
        end
        if (req.rd) begin
            case (req.addr)
                flash_mode_pkg::MODE_REG_ADDR: begin
                    state_next.rdata = mode_word;
                end
                flash_mode_pkg::CTRL_REG_ADDR: begin
                    state_next.rdata = state_reg.ctrl;
                end
                flash_mode_pkg::WPROT_REG_ADDR: begin
                    state_next.rdata = state_reg.modes.protection ? state_reg.wprot
                                                                  : '0;
                end
                flash_mode_pkg::RPROT_REG_ADDR: begin
                    state_next.rdata = state_reg.modes.protection ? state_reg.rprot
                                                                  : '0;
                end
                default: begin
                    state_next.rdata = '0;
                end
            endcase
        end
        state_next.en_out = {state_next.modes.prog_erase, state_next.modes.trim,
                             state_next.modes.bus_config, state_next.modes.protection,
                             state_next.modes.factory_test};
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg       <= '0;
            state_reg.idle  <= flash_mode_pkg::MODE_RESET[flash_mode_pkg::IDLE_BIT];
            state_reg.ctrl  <= flash_mode_pkg::CTRL_RESET;
            state_reg.wprot <= flash_mode_pkg::WPROT_RESET;
            state_reg.rprot <= flash_mode_pkg::RPROT_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata          = state_reg.rdata;
    assign flash_control_word = state_reg.ctrl;
    assign write_prot_word    = state_reg.wprot;
    assign read_prot_word     = state_reg.rprot;
    assign mode_enables       = state_reg.en_out;
endmodule // flash_mode_key_unlock
`default_nettype wire

/* File: dv/flash_mode_props.sv */
// Concurrent assertions for the flash mode key unlock block
`timescale 1ns/100ps
`default_nettype none
module flash_mode_props (
    input wire logic        ref_clk,            // Clock
    input wire logic        srst,               // Sync reset
    input wire logic [31:0] reg_addr,           // Address
    input wire logic [31:0] reg_wdata,          // Write data
    input wire logic        reg_wr,             // Write strobe
    input wire logic        reg_rd,             // Read strobe
    input wire logic        op_busy,            // Engine busy
    input wire logic [31:0] reg_rdata,          // Read data
    input wire logic [31:0] flash_control_word, // Control word
    input wire logic [31:0] write_prot_word,    // Write protection
    input wire logic [31:0] read_prot_word,     // Read protection
    input wire logic [4:0]  mode_enables        // Mode flags
);
    wire logic mw = reg_wr && reg_addr == flash_mode_pkg::MODE_REG_ADDR;
    logic [7:0] last_key;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Last key byte written, so a pair may span any gap of other traffic
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            last_key <= 8'h00;
        end else if (mw) begin
            last_key <= reg_wdata[7:0];
        end
    end
    sequence s_pair(logic [7:0] a, logic [7:0] b);
        mw && reg_wdata[7:0] == b && last_key == a;
    endsequence
    sequence s_lone(logic [7:0] a, logic [7:0] b, int i);
        mw && reg_wdata[7:0] == b && last_key != a && !mode_enables[i];
    endsequence
    property p_grant(logic [7:0] a, logic [7:0] b, int i);
        s_pair(a, b) |=> mode_enables[i];
    endproperty
    property p_no_skip(logic [7:0] a, logic [7:0] b, int i);
        s_lone(a, b, i) |=> !mode_enables[i];
    endproperty
    AST_PE_GRANT: assert property (p_grant(8'h5A, 8'hA5, 4))
        else $error("program erase mode not granted");
    AST_TRIM_GRANT: assert property (p_grant(8'hA5, 8'h5A, 3))
        else $error("trim mode not granted");
    AST_BUS_GRANT: assert property (p_grant(8'h81, 8'h28, 2))
        else $error("bus config mode not granted");
    AST_PROT_GRANT: assert property (p_grant(8'h66, 8'h99, 1))
        else $error("protection mode not granted");
    AST_TEST_GRANT: assert property (p_grant(8'h39, 8'h7D, 0))
        else $error("test mode not granted");
    AST_PE_NO_SKIP: assert property (p_no_skip(8'h5A, 8'hA5, 4))
        else $error("program erase mode granted out of order");
    AST_TRIM_NO_SKIP: assert property (p_no_skip(8'hA5, 8'h5A, 3))
        else $error("trim mode granted out of order");
    AST_MODE_CAUSE: assert property (mode_enables != $past(mode_enables) |-> $past(mw) || $past(mw, 2))
        else $error("mode changed without key write");
    AST_CTRL_LOCK: assert property (mode_enables[4:2] == 3'h0 |=> $stable(flash_control_word))
        else $error("control word changed without mode");
    AST_TEST_LOCK: assert property (!mode_enables[0] |=> $stable(flash_control_word[17:16]))
        else $error("test bits changed without test mode");
    AST_TRIM_LOCK: assert property (!mode_enables[3] |=> $stable(flash_control_word[30:28]))
        else $error("trim bits changed without trim mode");
    AST_BUS_LOCK: assert property (!mode_enables[2] |=> $stable({flash_control_word[31], flash_control_word[27:24]}))
        else $error("bus bits changed without bus mode");
    AST_PROT_LOCK: assert property (!mode_enables[1] |=> $stable(write_prot_word) && $stable(read_prot_word))
        else $error("protection changed without mode");
    AST_IDLE_BUSY: assert property (op_busy && $past(op_busy) && reg_rd && reg_addr == flash_mode_pkg::MODE_REG_ADDR |=> !reg_rdata[24])
        else $error("idle flag set while busy");
endmodule // flash_mode_props
bind flash_mode_key_unlock flash_mode_props flash_mode_props_inst (.ref_clk(ref_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .op_busy(op_busy),
    .reg_rdata(reg_rdata), .flash_control_word(flash_control_word),
    .write_prot_word(write_prot_word), .read_prot_word(read_prot_word), .mode_enables(mode_enables));
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking testbench for the flash mode key unlock block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam logic [31:0] MA = flash_mode_pkg::MODE_REG_ADDR;
    localparam logic [31:0] CA = flash_mode_pkg::CTRL_REG_ADDR;
    localparam logic [31:0] WA = flash_mode_pkg::WPROT_REG_ADDR;
    localparam logic [31:0] RA = flash_mode_pkg::RPROT_REG_ADDR;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic [31:0] reg_addr = 32'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        op_busy = 1'b0;
    logic        pend = 1'b0;
    logic [31:0] reg_rdata, flash_control_word, write_prot_word, read_prot_word;
    logic [4:0]  mode_enables, me;
    logic [31:0] q[$];
    logic [31:0] ctrl, wp, rp, ex;
    logic [7:0]  key;
    logic        bz;
    int          seed = 32;
    int          fail_count = 0;
    int          comparisons = 0;
    always #5 ref_clk = ~ref_clk;
    flash_mode_key_unlock flash_mode_key_unlock_inst (.ref_clk(ref_clk), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .op_busy(op_busy), .reg_rdata(reg_rdata), .flash_control_word(flash_control_word),
        .write_prot_word(write_prot_word), .read_prot_word(read_prot_word),
        .mode_enables(mode_enables));
    task automatic results;
        if (fail_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [31:0] exp_of(input logic [31:0] a);
        logic idle;
        idle = !(bz || ctrl[2] || ctrl[1]);
        case (a)
            MA: exp_of = {7'h0, idle, me[0], me[2], me[1], 3'h0, {2{me[3]}}, 6'h0, {2{me[4]}}, key};
            CA: exp_of = ctrl;
            WA: exp_of = me[1] ? wp : 32'h0;
            RA: exp_of = me[1] ? rp : 32'h0;
            default: exp_of = 32'h0;
        endcase
    endfunction
    function automatic logic [31:0] cmask();
        cmask = (me[4] ? flash_mode_pkg::CTRL_PE_MASK : 32'h0)
            & ~(me[0] ? 32'h0 : flash_mode_pkg::CTRL_TEST_MASK)
            | (me[3] ? flash_mode_pkg::CTRL_TRIM_MASK : 32'h0)
            | (me[2] ? flash_mode_pkg::CTRL_BUSCFG_MASK : 32'h0);
    endfunction
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bz = 1'($random(seed));
        op_busy <= bz;
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        if (a == MA) begin
            for (int i = 0; i < 5; i++)
                if (key == flash_mode_pkg::FIRST_KEYS[i*8 +: 8]
                    && d[7:0] == flash_mode_pkg::SECOND_KEYS[i*8 +: 8]) me[4-i] = 1'b1;
            key = d[7:0];
        end
        if (a == CA) ctrl = (ctrl & ~cmask()) | (d & cmask());
        if (a == WA && me[1]) wp = d;
        if (a == RA && me[1]) rp = d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge ref_clk);
        q.push_back(exp_of(a));
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rdall;
        rd(MA);
        rd(CA);
        rd(WA);
        rd(RA);
        rd(32'h40000100);
        chk("mode_enables", {27'h0, me}, {27'h0, mode_enables});
    endtask
    task automatic rst;
        srst <= 1'b1;
        op_busy <= 1'b0;
        bz = 1'b0;
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        me = 5'h0;
        key = 8'h0;
        ctrl = flash_mode_pkg::CTRL_RESET;
        wp = flash_mode_pkg::WPROT_RESET;
        rp = flash_mode_pkg::RPROT_RESET;
    endtask
    always @(posedge ref_clk) begin
        pend <= reg_rd;
        if (pend) begin
            ex = q.pop_front();
            chk("reg_rdata", ex, reg_rdata);
        end
    end
    initial begin
        rst();
        rdall();
        wr(CA, 32'hFFFFFFFF);
        wr(WA, 32'h0);
        wr(MA, {24'hFFFFFF, flash_mode_pkg::KEY_PE_1});
        wr(MA, 32'h000000C3);
        wr(MA, {24'h0, flash_mode_pkg::KEY_PE_2});
        wr(MA, 32'hFFFFFF00);
        rdall();
        for (int i = 0; i < 5; i++) begin
            wr(MA, {24'($random(seed)), flash_mode_pkg::FIRST_KEYS[i*8 +: 8]});
            wr(MA, {24'($random(seed)), flash_mode_pkg::SECOND_KEYS[i*8 +: 8]});
            wr(CA, $random(seed));
            wr(WA, $random(seed));
            wr(RA, $random(seed));
            rdall();
        end
        rst();
        rdall();
        results();
    end
    initial begin
        #500000;
        fail_count++;
        results();
    end
endmodule // tb_top
`default_nettype wire
